// *** design/asu_pkg.sv ***
// Purpose: Shared constants, state and bus types for the async serial unit
// Assumes: One 40 MHz clock; the inter-die clock is the system clock
// Notes:   Register map is a small private map on a plain strobe port
package asu_pkg;
	// Register bus geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int CTRL_W = 7;
	localparam int BAUD_W = 13;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_BAUD = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_STAT = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_DATA = 3'h3;

	// Control field positions
	localparam int CB_TE   = 0;  // transmitter_enable
	localparam int CB_RE   = 1;  // receiver_enable
	localparam int CB_SBK  = 2;  // send_break_bit
	localparam int CB_LBRK = 3;  // long_break_select
	localparam int CB_NINE = 4;  // Nine data bits
	localparam int CB_TINV = 5;  // transmit_invert
	localparam int CB_RINV = 6;  // receive_invert

	// Status field positions
	localparam int SB_TRANSMIT_BUFFER_EMPTY_FLAG = 0;
	localparam int SB_TC   = 1;
	localparam int SB_RECEIVE_FULL_FLAG = 2;
	localparam int SB_OVR  = 3;
	localparam int SB_NF   = 4;
	localparam int SB_FE   = 5;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic [BAUD_W-1:0] BAUD_RST = 13'h0001;

	// Baud chain: inter-die clock divided by four, then by the divisor
	localparam logic [1:0] PRE_LAST  = 2'h3;
	localparam logic [3:0] SUB_LAST  = 4'hF;
	localparam logic [4:0] SLOT_LAST = 5'h10;
	localparam logic [4:0] RT3       = 5'h03;
	localparam logic [4:0] RT5       = 5'h05;
	localparam logic [4:0] RT7       = 5'h07;
	localparam logic [4:0] RT8       = 5'h08;
	localparam logic [4:0] RT9       = 5'h09;
	localparam logic [4:0] RT10      = 5'h0A;

	// Frame and break lengths in bit times
	localparam logic [3:0] FRAME_8  = 4'hA;
	localparam logic [3:0] FRAME_9  = 4'hB;
	localparam logic [3:0] BRK_8    = 4'hA;
	localparam logic [3:0] BRK_9    = 4'hB;
	localparam logic [3:0] BRK_L8   = 4'hD;
	localparam logic [3:0] BRK_L9   = 4'hE;

	// Transmitter and receiver states, Gray except steps between REL and SHIFT and from DATA to HUNT
	typedef enum logic [1:0] {TX_REL = 2'b00, TX_IDLE = 2'b01, TX_SHIFT = 2'b11} asu_tx_type;
	typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11} asu_rx_type;

	// Register bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} asu_bus_type;

	// Whole block state
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [BAUD_W-1:0] baud;
		logic [1:0]        pre_cnt;
		logic [BAUD_W-1:0] div_cnt;
		logic [3:0]        tx_sub;
		asu_tx_type        tx_st;
		logic [13:0]       tx_sh;
		logic [3:0]        tx_left;
		logic [8:0]        tx_buf;
		logic              transmit_buffer_empty_flag;
		logic              tc;
		logic              idle_q;
		logic              brk_q;
		logic              tx_line;
		logic              tx_oe;
		asu_rx_type        rx_st;
		logic [2:0]        hist;
		logic [4:0]        slot;
		logic [3:0]        rx_idx;
		logic [1:0]        smp;
		logic [8:0]        rx_sh;
		logic              rx_noise;
		logic [8:0]        rx_buf;
		logic              receive_full_flag;
		logic              ovr;
		logic              nf;
		logic              fe;
		logic              armed;
		logic [DATA_W-1:0] rd_data;
	} asu_state_type;

	localparam asu_state_type ST_RST = '{ctrl: CTRL_RST, baud: BAUD_RST, tx_st: TX_REL, rx_st: RX_HUNT,
		transmit_buffer_empty_flag: 1'b1, tc: 1'b1, tx_line: 1'b1, tx_sh: 14'h3FFF, default: '0};
endpackage

// *** design/asu_core.sv ***
// Purpose: Async NRZ serial transmitter and receiver with shared baud chain
// Assumes: rx_in and bus strobes are synchronous to sys_clk_in
// Notes:   Pin is released (oe low) only when all queued activity is done
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// What this block does
// RULE1 - Baud chain runs from clock divided by four
// RULE2 - Output idles high; invert bit flips everything
// RULE3 - Enabling transmitter queues one idle preamble frame
// RULE4 - Shifter is ten bits, eleven in nine-bit
// RULE5 - Free shifter loads buffer, sets buffer-empty flag
// RULE6 - Nothing pending after stop: set complete, idle
// RULE7 - Pin held until queued work has finished
// RULE8 - Send-break queues break; held bit requeues
// RULE9 - Break lasts ten, eleven, thirteen, fourteen bits
// RULE10 - Enable toggle queues one idle character
// RULE11 - Receive invert; receiver runs only when enabled
// RULE12 - Frame: start zero, data LSB first, stop
// RULE13 - Stop received, buffer free: store, set full
// RULE14 - Buffer already full: overrun, drop character
// RULE15 - Full flag clears on status then data read
// RULE16 - Sixteen slots per bit; edge after three ones
// RULE17 - Start verified by two of three votes
// RULE18 - Bits resolved by majority of slots 8-10
// RULE19 - Verified start bit always counts as zero
// RULE20 - Any disagreeing sample sets noise flag
// RULE21 - Each falling edge after three ones resynchronises the slot counter
// RULE22 - Non-break framing error preloads three ones
// RULE23 - Framing error blocks buffer transfer, shifter runs
// RULE24 - Zero stop bit raises framing error flag
module asu_core (
	input  wire logic                 sys_clk_in,   // 40 MHz, also the inter-die clock
	input  wire logic                 sys_rst_in,   // Synchronous, active high
	input  wire asu_pkg::asu_bus_type bus_in,       // Register request
	input  wire logic                 rx_in,        // Serial receive line
	output logic [asu_pkg::DATA_W-1:0] rd_data_out, // Read data, cycle after the strobe
	output logic                      tx_out,       // Serial transmit line
	output logic                      tx_oe_out     // High while the block drives the pin
);
	asu_pkg::asu_state_type s;        // Registered state
	asu_pkg::asu_state_type n;        // Next state
	logic                   x16;      // 16x baud enable
	logic                   btick;    // Bit-time enable
	logic                   samp;     // Receive sample after inversion
	logic                   fall;     // Falling edge found
	logic                   adv;      // Advance to next received bit
	logic                   vote;     // Resolved bit level
	logic                   lvl;      // Level samples are checked against
	logic                   noise_now; // Noise including this bit
	logic                   ld_data;  // Data frame entered the shifter
	logic                   ld_brk;   // Break entered the shifter
	logic                   rx_done;  // Stop bit resolved
	logic                   brk_rx;   // Received frame was a break
	logic [8:0]             data9;    // Received data aligned to bit 0
	logic [3:0]             nbits;    // Data bits per frame

	// Two-of-three majority, shared by start check and bit resolve
	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction

	// Break length from long-break and nine-bit selects
	function automatic logic [3:0] brk_len(input logic lng, input logic nine);
		if (lng) begin
			brk_len = nine ? asu_pkg::BRK_L9 : asu_pkg::BRK_L8;
		end else begin
			brk_len = nine ? asu_pkg::BRK_9 : asu_pkg::BRK_8;
		end
	endfunction

	// All next-state logic
	always_comb begin
		n = s;
		n.rd_data = '0;
		x16 = 1'b0;
		ld_data = 1'b0;
		ld_brk = 1'b0;
		rx_done = 1'b0;
		fall = 1'b0;
		adv = 1'b0;
		vote = 1'b0;
		lvl = 1'b0;
		noise_now = s.rx_noise;
		brk_rx = 1'b0;
		nbits = s.ctrl[asu_pkg::CB_NINE] ? 4'h9 : 4'h8;
		data9 = s.ctrl[asu_pkg::CB_NINE] ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
		samp = rx_in ^ s.ctrl[asu_pkg::CB_RINV]; // [RULE11]

		// Prescale by four, then divisor; a zero divisor stops the chain
		n.pre_cnt = s.pre_cnt + 2'h1; // [RULE1]
		if (s.pre_cnt == asu_pkg::PRE_LAST) begin
			if (s.div_cnt + 13'h0001 >= s.baud) begin
				n.div_cnt = '0;
				x16 = (s.baud != '0);
			end else begin
				n.div_cnt = s.div_cnt + 13'h0001;
			end
		end
		// Same bit tick feeds the transmitter; receiver uses x16 directly
		if (x16) begin
			n.tx_sub = s.tx_sub + 4'h1;
		end
		btick = x16 && (s.tx_sub == asu_pkg::SUB_LAST);

		// Register writes; edge-triggered queue requests come from here
		if (bus_in.wr) begin
			if (bus_in.addr == asu_pkg::OFF_CTRL) begin
				n.ctrl = bus_in.wdata[asu_pkg::CTRL_W-1:0];
				if (bus_in.wdata[asu_pkg::CB_TE] && !s.ctrl[asu_pkg::CB_TE]) begin
					n.idle_q = 1'b1; // [RULE3] [RULE10]
				end
				if (bus_in.wdata[asu_pkg::CB_SBK] && !s.ctrl[asu_pkg::CB_SBK]) begin
					n.brk_q = 1'b1; // [RULE8]
				end
			end else if (bus_in.addr == asu_pkg::OFF_BAUD) begin
				n.baud = bus_in.wdata[asu_pkg::BAUD_W-1:0];
			end else if (bus_in.addr == asu_pkg::OFF_DATA) begin
				n.tx_buf = bus_in.wdata[8:0];
				n.transmit_buffer_empty_flag = 1'b0;
			end
		end

		// Register reads; status read arms the receive flag clear
		if (bus_in.rd) begin
			if (bus_in.addr == asu_pkg::OFF_CTRL) begin
				n.rd_data = {9'h000, s.ctrl};
			end else if (bus_in.addr == asu_pkg::OFF_BAUD) begin
				n.rd_data = {3'h0, s.baud};
			end else if (bus_in.addr == asu_pkg::OFF_STAT) begin
				n.rd_data[asu_pkg::SB_TRANSMIT_BUFFER_EMPTY_FLAG] = s.transmit_buffer_empty_flag;
				n.rd_data[asu_pkg::SB_TC] = s.tc;
				n.rd_data[asu_pkg::SB_RECEIVE_FULL_FLAG] = s.receive_full_flag;
				n.rd_data[asu_pkg::SB_OVR] = s.ovr;
				n.rd_data[asu_pkg::SB_NF] = s.nf;
				n.rd_data[asu_pkg::SB_FE] = s.fe;
				n.armed = s.receive_full_flag | s.ovr | s.nf | s.fe;
			end else if (bus_in.addr == asu_pkg::OFF_DATA) begin
				n.rd_data = {7'h00, s.rx_buf};
				if (s.armed) begin
					n.receive_full_flag = 1'b0; // [RULE15]
					n.ovr = 1'b0;
					n.nf = 1'b0;
					n.fe = 1'b0;
					n.armed = 1'b0;
				end
			end
		end

		// Transmitter: shift and load only on bit boundaries so loads align to baud
		if (btick) begin
			if (s.tx_st == asu_pkg::TX_SHIFT && s.tx_left != 4'h1) begin
				// Mid-frame: shift in idle ones behind the frame
				n.tx_sh = {1'b1, s.tx_sh[13:1]};
				n.tx_left = s.tx_left - 4'h1;
			end else if (n.idle_q) begin
				// Preamble or queued idle, one full frame of ones
				n.tx_sh = 14'h3FFF; // [RULE3] [RULE10]
				n.tx_left = s.ctrl[asu_pkg::CB_NINE] ? asu_pkg::FRAME_9 : asu_pkg::FRAME_8;
				n.idle_q = 1'b0;
				n.tx_st = asu_pkg::TX_SHIFT;
				n.tc = 1'b0;
			end else if (n.brk_q) begin
				// Break of all zeros; a held send-break queues another
				n.tx_sh = 14'h0000;
				n.tx_left = brk_len(s.ctrl[asu_pkg::CB_LBRK], s.ctrl[asu_pkg::CB_NINE]); // [RULE9]
				n.brk_q = n.ctrl[asu_pkg::CB_SBK]; // [RULE8]
				n.tx_st = asu_pkg::TX_SHIFT;
				n.tc = 1'b0;
				ld_brk = 1'b1;
			end else if (!n.transmit_buffer_empty_flag && s.ctrl[asu_pkg::CB_TE]) begin
				// Stop, data LSB first, start in bit 0 [RULE12]
				if (s.ctrl[asu_pkg::CB_NINE]) begin
					n.tx_sh = {3'h7, 1'b1, n.tx_buf, 1'b0}; // [RULE4]
					n.tx_left = asu_pkg::FRAME_9;
				end else begin
					n.tx_sh = {4'hF, 1'b1, n.tx_buf[7:0], 1'b0}; // [RULE4]
					n.tx_left = asu_pkg::FRAME_8;
				end
				n.transmit_buffer_empty_flag = 1'b1; // [RULE5]
				n.tx_st = asu_pkg::TX_SHIFT;
				n.tc = 1'b0;
				ld_data = 1'b1;
			end else begin
				// Nothing left: complete, and release only when disabled
				if (s.tx_st == asu_pkg::TX_SHIFT) begin
					n.tc = 1'b1; // [RULE6]
				end
				n.tx_sh = 14'h3FFF;
				n.tx_left = 4'h0;
				// Next control value, so an enable written on this tick keeps the pin
				n.tx_st = n.ctrl[asu_pkg::CB_TE] ? asu_pkg::TX_IDLE : asu_pkg::TX_REL; // [RULE7]
			end
		end else if (s.tx_st == asu_pkg::TX_REL && n.ctrl[asu_pkg::CB_TE]) begin
			// Take the pin at once; the preamble starts at the next bit
			n.tx_st = asu_pkg::TX_IDLE;
		end

		// Receiver, clocked by the 16x enable
		if (!s.ctrl[asu_pkg::CB_RE]) begin
			// Disabled: forget history so a fresh edge needs three ones
			n.rx_st = asu_pkg::RX_HUNT; // [RULE11]
			n.hist = 3'h0;
		end else if (x16) begin
			fall = (s.hist == 3'h7) && !samp; // [RULE16]
			n.hist = {s.hist[1:0], samp};
			// A falling edge after three ones restarts the slot count at the boundary
			// The falling sample is RT1 itself, so the following tick is RT2
			if (fall) begin
				n.slot = 5'h02; // [RULE21]
			end else begin
				n.slot = (s.slot == asu_pkg::SLOT_LAST) ? 5'h01 : s.slot + 5'h01;
			end
			adv = (s.slot == asu_pkg::SLOT_LAST) || (fall && s.slot > asu_pkg::RT10);
			vote = maj3(s.smp[1], s.smp[0], samp);
			if (s.rx_st == asu_pkg::RX_HUNT) begin
				if (fall) begin
					n.rx_st = asu_pkg::RX_START;
					n.rx_noise = 1'b0;
					n.rx_idx = 4'h0;
				end
			end else begin
				// Keep the two earlier samples of each vote
				if (s.slot == asu_pkg::RT3 || s.slot == asu_pkg::RT5 ||
					s.slot == asu_pkg::RT8 || s.slot == asu_pkg::RT9) begin
					n.smp = {s.smp[0], samp};
				end
				if (s.rx_st == asu_pkg::RX_START && s.slot == asu_pkg::RT7) begin
					if (vote) begin
						n.rx_st = asu_pkg::RX_HUNT; // [RULE17]
					end else begin
						n.rx_noise = s.rx_noise | (s.smp != 2'h0) | samp; // [RULE20]
					end
				end
				if (s.slot == asu_pkg::RT10) begin
					// Start is zero by definition once verified
					lvl = (s.rx_st == asu_pkg::RX_START) ? 1'b0 : vote; // [RULE18] [RULE19]
					noise_now = s.rx_noise | ({s.smp, samp} != {3{lvl}}); // [RULE20]
					n.rx_noise = noise_now;
					if (s.rx_st == asu_pkg::RX_DATA && s.rx_idx <= nbits) begin
						n.rx_sh = {lvl, s.rx_sh[8:1]}; // [RULE12]
					end else if (s.rx_st == asu_pkg::RX_DATA) begin
						rx_done = 1'b1;
						n.rx_st = asu_pkg::RX_HUNT;
						brk_rx = (data9 == 9'h000) && !lvl;
						if (!lvl && !brk_rx) begin
							n.hist = 3'h7; // [RULE22]
						end
						// Set wins over a same-cycle clear: test the next values
						if (n.fe) begin
							n.ovr = s.ovr; // [RULE23]
						end else if (n.receive_full_flag) begin
							n.ovr = 1'b1; // [RULE14]
						end else begin
							n.rx_buf = data9; // [RULE13]
							n.receive_full_flag = 1'b1;
							n.nf = noise_now; // [RULE20]
							n.fe = !lvl; // [RULE24]
						end
					end
				end
				if (adv && n.rx_st != asu_pkg::RX_HUNT) begin
					n.rx_idx = s.rx_idx + 4'h1;
					n.rx_st = asu_pkg::RX_DATA;
				end
			end
		end

		// Pin level: idle ones when not shifting, then polarity
		n.tx_line = ((n.tx_st == asu_pkg::TX_SHIFT) ? n.tx_sh[0] : 1'b1) ^ n.ctrl[asu_pkg::CB_TINV]; // [RULE2]
		n.tx_oe = (n.tx_st != asu_pkg::TX_REL); // [RULE7]
	end

	// State register
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			s <= asu_pkg::ST_RST;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from flip-flops
	assign rd_data_out = s.rd_data;
	assign tx_out = s.tx_line;
	assign tx_oe_out = s.tx_oe;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// Status read with the full flag set, then a data read
	sequence seq_stat_rd;
		bus_in.rd && bus_in.addr == asu_pkg::OFF_STAT && s.receive_full_flag;
	endsequence
	sequence seq_data_rd;
		bus_in.rd && bus_in.addr == asu_pkg::OFF_DATA;
	endsequence

	chk_idle_level: assert property (s.tx_st != asu_pkg::TX_SHIFT |-> s.tx_line == !s.ctrl[asu_pkg::CB_TINV]) // [RULE2]
		else $error("idle line level wrong");
	chk_te_preamble: assert property (bus_in.wr && bus_in.addr == asu_pkg::OFF_CTRL &&
		bus_in.wdata[asu_pkg::CB_TE] && !s.ctrl[asu_pkg::CB_TE] |=> s.idle_q) // [RULE3]
		else $error("enable did not queue preamble");
	chk_frame_len: assert property (ld_data |=> s.tx_left ==
		($past(s.ctrl[asu_pkg::CB_NINE]) ? 4'hB : 4'hA)) // [RULE4]
		else $error("frame length wrong");
	chk_transmit_buffer_empty_flag_set: assert property (ld_data |=> s.transmit_buffer_empty_flag && s.tx_st == asu_pkg::TX_SHIFT) // [RULE5]
		else $error("buffer empty flag not set on load");
	chk_tc_idle: assert property ($rose(s.tc) |-> s.tx_st != asu_pkg::TX_SHIFT) // [RULE6]
		else $error("complete set while shifting");
	chk_pin_release: assert property ($fell(s.tx_oe) |-> !s.idle_q && !s.brk_q && !s.ctrl[asu_pkg::CB_TE]) // [RULE7]
		else $error("pin released with work pending");
	chk_break_len: assert property (ld_brk |=> s.tx_left ==
		brk_len($past(s.ctrl[asu_pkg::CB_LBRK]), $past(s.ctrl[asu_pkg::CB_NINE])) && s.tx_sh[0] == 1'b0) // [RULE9]
		else $error("break length wrong");
	chk_overrun_set: assert property (rx_done && s.receive_full_flag && !s.fe && !bus_in.rd |=> s.ovr && $stable(s.rx_buf)) // [RULE14]
		else $error("overrun not flagged");
	chk_receive_full_flag_clear: assert property (seq_stat_rd ##[1:2] seq_data_rd |=> !s.receive_full_flag || $past(rx_done)) // [RULE15]
		else $error("full flag not cleared");
	chk_fe_block: assert property (rx_done && s.fe && !bus_in.rd |=> $stable(s.rx_buf) && s.fe) // [RULE23]
		else $error("transfer while framing error set");
endmodule

// *** verification/asu_node.sv ***
// Purpose: Remote serial node that drives the receive line and decodes the transmit line
// Assumes: Divisor register left at one, so one bit lasts 64 clocks
// Notes:   The node always drives its line, as a real transmitter does
`timescale 1ns/1ps
module asu_node (
	input  wire logic sys_clk_in, // Bench clock
	input  wire logic tx_in,      // Block's transmit line
	output logic      line_out    // Block's receive line
);
	localparam int BIT = 64; // Clocks per bit at divisor one

	initial line_out = 1'b1;

	// Two idle bits, start, data LSB first, stop, idle; bit g spoils one centre sample
	task automatic send(input logic [8:0] d, input logic nine, input logic stop, input logic inv,
		input logic [3:0] g);
		logic [13:0] f;
		f = nine ? {1'b1, stop, d, 1'b0, 2'b11} : {2'b11, stop, d[7:0], 1'b0, 2'b11};
		for (int i = 0; i < 14; i++) begin
			@(posedge sys_clk_in);
			line_out <= f[i] ^ inv;
			repeat (32) @(posedge sys_clk_in);
			// Four clocks cover exactly one 16x tick, so the vote still wins
			if (i == g + 2)
				line_out <= ~(f[i] ^ inv);
			repeat (4) @(posedge sys_clk_in);
			line_out <= f[i] ^ inv;
			repeat (27) @(posedge sys_clk_in);
		end
	endtask

	// Waits for a start edge, then samples each bit in its middle
	task automatic recv(input logic nine, output logic [8:0] d, output logic stop, output int waited);
		d = '0;
		for (waited = 0; waited < 3000 && tx_in !== 1'b0; waited++)
			@(posedge sys_clk_in);
		repeat (BIT / 2) @(posedge sys_clk_in);
		for (int k = 0; k < (nine ? 9 : 8); k++) begin
			repeat (BIT) @(posedge sys_clk_in);
			d[k] = tx_in;
		end
		repeat (BIT) @(posedge sys_clk_in);
		stop = tx_in;
	endtask
endmodule

// *** verification/asu_core_tb.sv ***
// Purpose: Self-checking bench for the async serial unit
// Assumes: Divisor one, so one bit is 64 clocks
// Notes:   Receive cases run from a table; transmit and error cases are written out
`timescale 1ns/1ps
module asu_core_tb;
	localparam logic [15:0] TE   = 16'h0001 << asu_pkg::CB_TE;   // Control bits
	localparam logic [15:0] RE   = 16'h0001 << asu_pkg::CB_RE;
	localparam logic [15:0] SEND_BREAK_BIT  = 16'h0001 << asu_pkg::CB_SBK;
	localparam logic [15:0] NINE = 16'h0001 << asu_pkg::CB_NINE;
	localparam logic [15:0] TINV = 16'h0001 << asu_pkg::CB_TINV;
	localparam logic [15:0] RINV = 16'h0001 << asu_pkg::CB_RINV;
	localparam int          BLEN [4] = '{10, 13, 11, 14}; // Break bits by mode

	// One receive case: control, data, spoiled bit (F none), status expected
	typedef struct packed {
		logic [15:0] ctrl;
		logic [8:0]  d;
		logic [3:0]  g;
		logic [15:0] st;
	} asu_row_type;

	localparam asu_row_type ROWS [6] = '{
		'{RE, 9'h0A5, 4'hF, 16'h0007},
		'{RE | NINE, 9'h1C3, 4'hF, 16'h0007},
		'{RE | RINV, 9'h05A, 4'hF, 16'h0007},
		'{16'h0000, 9'h0FF, 4'hF, 16'h0003},
		'{RE, 9'h0A4, 4'h1, 16'h0017},
		'{RE, 9'h0B3, 4'h0, 16'h0017}};

	logic                 sys_clk_in;   // 40 MHz clock
	logic                 sys_rst_in;   // Synchronous reset
	asu_pkg::asu_bus_type bus;          // Register request
	logic                 rx_line;      // Node to block
	logic [15:0]          rd_data;      // Read data
	logic                 tx_line;      // Block to node
	logic                 tx_oe;        // Pin drive enable
	int                   n_fail;       // Mismatches
	int                   total_checks; // Comparisons

	asu_core DUT (
		.sys_clk_in  (sys_clk_in),
		.sys_rst_in  (sys_rst_in),
		.bus_in      (bus),
		.rx_in       (rx_line),
		.rd_data_out (rd_data),
		.tx_out      (tx_line),
		.tx_oe_out   (tx_oe)
	);

	asu_node node (
		.sys_clk_in (sys_clk_in),
		.tx_in      (tx_line),
		.line_out   (rx_line)
	);

	// Free-running clock, 25 ns period
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	// Prints the counts and the verdict, then stops
	task automatic close_out();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// A wait that ran out counts as a mismatch and ends the run
	task automatic fail(input string msg);
		n_fail++;
		$display("wrong value at %0t: %s", $time, msg);
		close_out();
	endtask

	// Register word compare
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	// Line level or condition compare
	task automatic check_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: level %b expected %b", $time, got, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge sys_clk_in);
		bus.wr <= 1'b0;
	endtask

	// One-cycle read strobe; data stand only in the following cycle
	task automatic rd(input logic [2:0] a, output logic [15:0] q);
		@(posedge sys_clk_in);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge sys_clk_in);
		bus.rd <= 1'b0;
		#1 q = rd_data;
	endtask

	// Reads status until the buffer-empty flag shows
	task automatic poll(output logic [15:0] q);
		for (int k = 0; k < 400; k++) begin
			rd(asu_pkg::OFF_STAT, q);
			if (q[asu_pkg::SB_TRANSMIT_BUFFER_EMPTY_FLAG] === 1'b1)
				return;
		end
		fail("status wait");
	endtask

	// Counts clocks until the line (or enable) reaches a level
	task automatic wait_tx(input logic oe, input logic lvl, input int lim, output int n);
		for (n = 0; n < lim && (oe ? tx_oe : tx_line) !== lvl; n++)
			@(posedge sys_clk_in);
		if (n >= lim)
			fail("line wait");
	endtask

	// Run-time guard
	initial begin
		repeat (100000) @(posedge sys_clk_in);
		fail("run time");
	end

	// Main sequence
	initial begin
		logic [15:0] q;
		logic [8:0]  d;
		logic        s;
		int          w;
		int          n;
		bus = '0;
		sys_rst_in = 1'b1;
		n_fail = 0;
		total_checks = 0;
		repeat (10) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		#1;
		check_bit(tx_line, 1'b1);
		check_bit(tx_oe, 1'b0);
		check_val(rd_data, 16'h0000);
		rd(asu_pkg::OFF_BAUD, q);
		check_val(q, 16'h0001);
		rd(asu_pkg::OFF_STAT, q);
		check_val(q, 16'h0003);
		wr(3'h5, 16'hFFFF);
		rd(3'h5, q);
		check_val(q, 16'h0000);
		rd(asu_pkg::OFF_CTRL, q);
		check_val(q, 16'h0000);
		$display("reset test done");

		// Ordinary receive cases
		foreach (ROWS[i]) begin
			wr(asu_pkg::OFF_CTRL, ROWS[i].ctrl);
			node.send(ROWS[i].d, ROWS[i].ctrl[asu_pkg::CB_NINE], 1'b1, ROWS[i].ctrl[asu_pkg::CB_RINV], ROWS[i].g);
			rd(asu_pkg::OFF_STAT, q);
			check_val(q, ROWS[i].st);
			if (ROWS[i].st[asu_pkg::SB_RECEIVE_FULL_FLAG]) begin
				rd(asu_pkg::OFF_DATA, q);
				check_val(q, 16'(ROWS[i].d));
			end
			rd(asu_pkg::OFF_STAT, q);
			check_val(q, 16'h0003);
			$display("receive row %0d done", i);
		end

		// Second character while the first is unread; data read alone does not clear
		wr(asu_pkg::OFF_CTRL, RE);
		node.send(9'h031, 1'b0, 1'b1, 1'b0, 4'hF);
		node.send(9'h032, 1'b0, 1'b1, 1'b0, 4'hF);
		rd(asu_pkg::OFF_DATA, q);
		check_val(q, 16'h0031);
		rd(asu_pkg::OFF_STAT, q);
		check_val(q, 16'h000F);
		rd(asu_pkg::OFF_DATA, q);
		check_val(q, 16'h0031);
		rd(asu_pkg::OFF_STAT, q);
		check_val(q, 16'h0003);
		$display("overrun test done");

		// Low stop bit, then a good character that must be held back
		node.send(9'h03C, 1'b0, 1'b0, 1'b0, 4'hF);
		node.send(9'h011, 1'b0, 1'b1, 1'b0, 4'hF);
		repeat (700) @(posedge sys_clk_in);
		rd(asu_pkg::OFF_STAT, q);
		check_val(q, 16'h0027);
		rd(asu_pkg::OFF_DATA, q);
		check_val(q, 16'h003C);
		rd(asu_pkg::OFF_STAT, q);
		check_val(q, 16'h0003);
		$display("framing test done");

		// Preamble, then two characters back to back
		wr(asu_pkg::OFF_CTRL, TE);
		wr(asu_pkg::OFF_DATA, 16'h00C5);
		fork
			node.recv(1'b0, d, s, w);
			begin
				poll(q);
				check_val(q, 16'h0001);
				wr(asu_pkg::OFF_DATA, 16'h003A);
			end
		join
		check_bit(w >= 630 && w <= 720, 1'b1);
		check_val(16'(d), 16'h00C5);
		check_bit(s, 1'b1);
		node.recv(1'b0, d, s, w);
		check_bit(w < 64, 1'b1);
		check_val(16'(d), 16'h003A);
		repeat (64) @(posedge sys_clk_in);
		rd(asu_pkg::OFF_STAT, q);
		check_val(q, 16'h0003);
		check_bit(tx_line, 1'b1);
		$display("transmit test done");

		// Break in every length mode, enable dropped while it is queued
		for (int m = 0; m < 4; m++) begin
			wr(asu_pkg::OFF_CTRL, TE | SEND_BREAK_BIT | (16'(m) << asu_pkg::CB_LBRK));
			wr(asu_pkg::OFF_CTRL, 16'(m) << asu_pkg::CB_LBRK);
			wait_tx(1'b0, 1'b0, 2000, w);
			check_bit(tx_oe, 1'b1);
			wait_tx(1'b0, 1'b1, 1000, n);
			check_val(16'((n + 32) / 64), 16'(BLEN[m]));
			wait_tx(1'b1, 1'b0, 300, w);
			$display("break mode %0d done", m);
		end

		// Inverted idle level with the transmitter off
		wr(asu_pkg::OFF_CTRL, TINV);
		repeat (3) @(posedge sys_clk_in);
		check_bit(tx_line, 1'b0);
		$display("invert test done");
		close_out();
	end
endmodule
